// *** include/mps_pkg.sv ***
/*
 * mps_pkg: constants and types shared by the microprogram sequencer and
 * its successor decoder.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package mps_pkg;
    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W     = 14;
    localparam int unsigned WORD_W     = 16;
    localparam logic [13:0] ADDR_RESET = 14'h0000;
    localparam logic [13:0] INC_ONE    = 14'h0001;
    localparam logic [13:0] INC_TWO    = 14'h0002;

    // ------------------------------------------------------------------
    // microprogram word field positions (bit 1 is the msb, index 15)
    // ------------------------------------------------------------------
    localparam int unsigned CTL_B1     = 15;
    localparam int unsigned CTL_B2     = 14;
    localparam int unsigned CTL_B3     = 13;
    localparam int unsigned CTL_B4     = 12;
    localparam int unsigned ADDR_MSB   = 13;
    localparam int unsigned ADDR_LSB   = 0;

    // ------------------------------------------------------------------
    // successor codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SUCC_WAIT = 3'h0,
        SUCC_STEP = 3'h1,
        SUCC_SAVE = 3'h2,
        SUCC_SKIP = 3'h3,
        SUCC_OUT_OF_LINE_ONCE = 3'h4,
        SUCC_JUMP = 3'h5,
        SUCC_CALL = 3'h6,
        SUCC_RETURN_SUCCESSOR = 3'h7
    } mps_succ_t;

    // one-hot sequencing phase
    typedef enum logic [1:0] {
        PH_IDLE = 2'h1,
        PH_ONE  = 2'h2
    } mps_phase_t;
endpackage

// *** include/mps_ctl_if.sv ***
/*
 * mps_ctl_if: decoded next-address controls passed from the successor
 * decoder to the sequencer datapath.
 * assumes: both ends share one clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface mps_ctl_if;
    logic [2:0] succ_code;      // selected successor
    logic       long_form;      // long-form word active
    logic       branch_or_call; // long-form jump or call
    logic       direct_call;    // long-form call
    logic       pc_plus_one;
    logic       pc_plus_two;
    logic       alt_plus_one;
    logic       alt_plus_two;
    logic       pc_load_en;
    logic       latch_load_en;
    logic       save_pc_to_alt;
    logic       phase3_inhibit;

    modport decoder (output succ_code, long_form, branch_or_call, direct_call, pc_plus_one, pc_plus_two,
                     alt_plus_one, alt_plus_two, pc_load_en, latch_load_en, save_pc_to_alt, phase3_inhibit);
    modport datapath (input succ_code, long_form, branch_or_call, direct_call, pc_plus_one, pc_plus_two,
                      alt_plus_one, alt_plus_two, pc_load_en, latch_load_en, save_pc_to_alt, phase3_inhibit);
endinterface
`default_nettype wire

// *** rtl/mps_succ_decode.sv ***
/*
 * mps_succ_decode: combinational successor and word-type decode.
 * assumes: inputs are stable around the phase 1 strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module mps_succ_decode (
    input  wire logic        i_condition_result,     // condition result
    input  wire logic [2:0]  i_true_succ,            // true successor code
    input  wire logic [2:0]  i_false_succ,           // false successor code
    input  wire logic        i_phase3_cond,          // phase3 conditional bit
    input  wire logic [15:0] i_word,                 // microprogram store word
    input  wire logic        i_force_long_form,      // force long form
    input  wire logic        i_seq_mode_n,           // sequential mode, low active
    input  wire logic        i_manual_step,          // manual step
    input  wire logic        i_clear,                // clear
    input  wire logic        i_hold_sequencer,       // hold sequencer
    mps_ctl_if.decoder       ctl                     // decoded controls
);
    // ------------------------------------------------------------------
    // word type decode
    // ------------------------------------------------------------------
    wire logic b1 = i_word[mps_pkg::CTL_B1];
    wire logic b2 = i_word[mps_pkg::CTL_B2];
    wire logic b3 = i_word[mps_pkg::CTL_B3];
    wire logic b4 = i_word[mps_pkg::CTL_B4];
    // forcing terms stop the word being read as a branch target
    wire logic forced_seq = i_force_long_form | ~i_seq_mode_n;
    wire logic lf_jump    = ~b1 & b2 & ~forced_seq;
    wire logic lf_call    = b1 & ~b2 & ~forced_seq;
    wire logic long_form  = ~(b1 & b2 & b3 & b4) | forced_seq | i_manual_step | i_clear;

    // successor selection by the condition result
    wire logic [2:0] succ = i_condition_result ? i_true_succ : i_false_succ;
    wire logic s_wait = (succ == mps_pkg::SUCC_WAIT);
    wire logic s_out_of_line_once = (succ == mps_pkg::SUCC_OUT_OF_LINE_ONCE);
    wire logic s_save = (succ == mps_pkg::SUCC_SAVE);
    wire logic s_skip = (succ == mps_pkg::SUCC_SKIP);
    wire logic s_jmp  = (succ == mps_pkg::SUCC_JUMP) | (succ == mps_pkg::SUCC_CALL);
    wire logic s_return_successor = (succ == mps_pkg::SUCC_RETURN_SUCCESSOR);

    // ------------------------------------------------------------------
    // control outputs; long form overrides the successor
    // ------------------------------------------------------------------
    assign ctl.succ_code      = succ;
    assign ctl.long_form      = long_form;
    assign ctl.direct_call    = lf_call;
    assign ctl.branch_or_call = lf_jump | lf_call;
    assign ctl.pc_plus_one    = long_form | (~s_wait & ~s_skip & ~s_jmp & ~s_out_of_line_once & ~s_return_successor);
    assign ctl.pc_plus_two    = ~long_form & s_skip;
    assign ctl.alt_plus_one   = ~long_form & (s_jmp | s_out_of_line_once);
    assign ctl.alt_plus_two   = ~long_form & s_return_successor;
    assign ctl.pc_load_en     = (long_form | (~s_wait & ~s_out_of_line_once)) & ~i_hold_sequencer;
    assign ctl.latch_load_en  = (long_form | ~s_wait) & ~i_hold_sequencer;
    assign ctl.save_pc_to_alt = lf_call | (~long_form & (s_save | (succ == mps_pkg::SUCC_CALL)));
    assign ctl.phase3_inhibit = long_form | (~i_condition_result & i_phase3_cond);
endmodule
`default_nettype wire

// *** rtl/mps_sequencer.sv ***
/*
 * mps_sequencer: next-address sequencer for the microprogram store.
 * assumes: a single system clock; phase 1 strobe marks the address
 * update cycle; inputs synchronous to the clock.
 */
`timescale 1ns/1ns
`default_nettype none
module mps_sequencer (
    input  wire logic        I_CLK_SYS,              // system clock
    input  wire logic        I_RST,                  // synchronous reset
    input  wire logic        i_phase1,               // phase 1 strobe
    input  wire logic        i_phase3,               // phase 3 strobe
    input  wire logic        i_condition_result,     // condition result
    input  wire logic [2:0]  i_true_succ_code,       // true successor nanobits
    input  wire logic [2:0]  i_false_succ_code,      // false successor nanobits
    input  wire logic        i_phase3_conditional_bit, // phase3 conditional nanobit
    input  wire logic [15:0] i_microprogram_store,   // current store word
    input  wire logic        i_force_long_form,      // force long form
    input  wire logic        i_seq_mode_n,           // sequential mode, low active
    input  wire logic        i_manual_step,          // manual step
    input  wire logic        i_clear,                // clear
    input  wire logic        i_hold_sequencer,       // hold sequencer
    output logic [13:0]      o_micro_pc,             // counter
    output logic [13:0]      o_alternate_micro_pc,   // alternate address
    output logic [13:0]      o_next_address_latch,   // incrementer latch
    output logic             o_long_form_instr,      // long form indicator
    output logic             o_phase3_inhibit,       // phase 3 inhibit
    output logic             o_phase3_enable,        // phase 3 operations run
    output logic             o_load_alt_from_word,   // word loads alternate
    output logic             o_load_shift_amount,    // word loads shift amount
    output logic             o_load_constant,        // word loads constant
    output logic             o_short_form,           // short form word
    output logic [7:0]       o_nano_address,         // nano address field
    output logic [2:0]       o_succ_code             // successor captured
);
    // ------------------------------------------------------------------
    // decoder
    // ------------------------------------------------------------------
    mps_ctl_if ctl ();

    mps_succ_decode u_dec (
        .i_condition_result (i_condition_result),
        .i_true_succ        (i_true_succ_code),
        .i_false_succ       (i_false_succ_code),
        .i_phase3_cond      (i_phase3_conditional_bit),
        .i_word             (i_microprogram_store),
        .i_force_long_form  (i_force_long_form),
        .i_seq_mode_n       (i_seq_mode_n),
        .i_manual_step      (i_manual_step),
        .i_clear            (i_clear),
        .i_hold_sequencer   (i_hold_sequencer),
        .ctl                (ctl)
    );

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [13:0] pc_q,  pc_d;
    logic [13:0] alt_q, alt_d;
    logic [13:0] lat_q, lat_d;
    logic [2:0]  succ_q;
    logic        lf_q, p3i_q, p3e_q;
    logic        ld_alt_q, ld_sar_q, ld_lit_q, short_q;
    logic [7:0]  nano_q;
    mps_pkg::mps_phase_t phase_q, phase_d;

    // ------------------------------------------------------------------
    // incrementer source selection and adders
    // ------------------------------------------------------------------
    wire logic [13:0] word_addr = i_microprogram_store[mps_pkg::ADDR_MSB:mps_pkg::ADDR_LSB];
    // branch-or-call swaps the counter for the word address on the plus one path
    wire logic [13:0] m_src     = ctl.branch_or_call ? word_addr : pc_q;
    wire logic [13:0] m_plus1   = m_src + mps_pkg::INC_ONE;
    wire logic [13:0] m_plus2   = pc_q + mps_pkg::INC_TWO;
    wire logic [13:0] a_plus1   = alt_q + mps_pkg::INC_ONE;
    wire logic [13:0] a_plus2   = alt_q + mps_pkg::INC_TWO;
    // one-hot select; on wait no select is active and the load enables are off
    wire logic [13:0] inc_out   = ({14{ctl.pc_plus_one}}  & m_plus1) |
                                  ({14{ctl.pc_plus_two}}  & m_plus2) |
                                  ({14{ctl.alt_plus_one}} & a_plus1) |
                                  ({14{ctl.alt_plus_two}} & a_plus2);
    wire logic        upd       = i_phase1;

    // word routing by leading control bits
    wire logic [3:0] ctl_bits = i_microprogram_store[mps_pkg::CTL_B1:mps_pkg::CTL_B4];
    wire logic       rt_alt   = (ctl_bits[3:2] == 2'h0);
    wire logic       rt_sar   = (ctl_bits == 4'hC) | (ctl_bits == 4'hD);
    wire logic       rt_lit   = (ctl_bits == 4'hC) | (ctl_bits == 4'hE);
    wire logic       rt_short = (ctl_bits == 4'hF);

    // ------------------------------------------------------------------
    // next-state: counter, alternate and latch
    // ------------------------------------------------------------------
    always_comb begin
        pc_d  = pc_q;
        alt_d = alt_q;
        lat_d = lat_q;
        if (upd) begin
            if (ctl.pc_load_en) begin
                pc_d = inc_out;
            end
            if (ctl.latch_load_en) begin
                lat_d = inc_out;
            end
            // the alternate takes the counter value present before this update
            if (ctl.save_pc_to_alt) begin
                alt_d = pc_q;
            end
        end
        // wait leaves all three unchanged through the defaults
        if (i_clear) begin
            pc_d  = mps_pkg::ADDR_RESET;
            alt_d = mps_pkg::ADDR_RESET;
            lat_d = mps_pkg::ADDR_RESET;
        end
    end

    // ------------------------------------------------------------------
    // phase tracker
    // ------------------------------------------------------------------
    always_comb begin
        unique case (phase_q)
            mps_pkg::PH_IDLE: phase_d = i_phase1 ? mps_pkg::PH_ONE : mps_pkg::PH_IDLE;
            mps_pkg::PH_ONE:  phase_d = i_phase1 ? mps_pkg::PH_ONE : mps_pkg::PH_IDLE;
            default:          phase_d = mps_pkg::PH_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // address registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            pc_q    <= mps_pkg::ADDR_RESET;
            alt_q   <= mps_pkg::ADDR_RESET;
            lat_q   <= mps_pkg::ADDR_RESET;
            phase_q <= mps_pkg::PH_IDLE;
        end else begin
            pc_q    <= pc_d;
            alt_q   <= alt_d;
            lat_q   <= lat_d;
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------------
    // captured controls and status, registered so outputs stay clean
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            succ_q   <= 3'h1;
            lf_q     <= 1'b0;
            p3i_q    <= 1'b0;
            p3e_q    <= 1'b0;
            ld_alt_q <= 1'b0;
            ld_sar_q <= 1'b0;
            ld_lit_q <= 1'b0;
            short_q  <= 1'b0;
            nano_q   <= 8'h00;
        end else if (upd) begin
            succ_q   <= ctl.succ_code;
            lf_q     <= ctl.long_form;
            p3i_q    <= ctl.phase3_inhibit;
            p3e_q    <= ~ctl.phase3_inhibit;
            ld_alt_q <= rt_alt;
            ld_sar_q <= rt_sar;
            ld_lit_q <= rt_lit;
            short_q  <= rt_short;
            nano_q   <= i_microprogram_store[7:0];
        end
    end

    // ------------------------------------------------------------------
    // outputs; phase 3 enable only pulses on the phase 3 strobe
    // ------------------------------------------------------------------
    assign o_micro_pc           = pc_q;
    assign o_alternate_micro_pc = alt_q;
    assign o_next_address_latch = lat_q;
    assign o_long_form_instr    = lf_q;
    assign o_phase3_inhibit     = p3i_q;
    assign o_phase3_enable      = p3e_q & i_phase3;
    assign o_load_alt_from_word = ld_alt_q;
    assign o_load_shift_amount  = ld_sar_q;
    assign o_load_constant      = ld_lit_q;
    assign o_short_form         = short_q;
    assign o_nano_address       = nano_q;
    assign o_succ_code          = succ_q;
endmodule
`default_nettype wire

// *** testbench/mps_sequencer_chk.sv ***
/* mps_sequencer_chk: concurrent checks on the sequencer's top-level ports.
   assumes: bound to mps_sequencer; one clock, synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module mps_sequencer_chk (
    input wire logic        I_CLK_SYS, I_RST,                                 // clock and reset
    input wire logic        i_phase1, i_phase3, i_condition_result,           // strobes, condition
    input wire logic [2:0]  i_true_succ_code, i_false_succ_code,              // successor groups
    input wire logic        i_phase3_conditional_bit,                         // phase 3 conditional
    input wire logic [15:0] i_microprogram_store,                             // store word
    input wire logic        i_force_long_form, i_seq_mode_n, i_manual_step,   // long-form forcing
    input wire logic        i_clear, i_hold_sequencer,                        // clear and hold
    input wire logic [13:0] o_micro_pc, o_alternate_micro_pc, o_next_address_latch, // registers
    input wire logic        o_long_form_instr, o_phase3_inhibit, o_phase3_enable,    // indicators
    input wire logic [2:0]  o_succ_code                                       // captured successor
);
    // -----------------------------------------------------------------
    // what the inputs ask for this cycle
    // -----------------------------------------------------------------
    wire logic [2:0]  sel_code  = i_condition_result ? i_true_succ_code : i_false_succ_code;
    wire logic        lf        = (i_microprogram_store[15:12] != 4'hF) | i_force_long_form | ~i_seq_mode_n
                                  | i_manual_step | i_clear;
    wire logic        inh_want  = lf | (~i_condition_result & i_phase3_conditional_bit);
    wire logic        upd       = i_phase1 & ~i_hold_sequencer & ~i_clear; // a free update, not held or cleared
    wire logic [13:0] word_addr = i_microprogram_store[13:0];

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);

    succ_pick_a: assert property (i_phase1 && !i_clear |=> o_succ_code == $past(sel_code))
        else $error("successor not taken from selected group");
    wait_keep_a: assert property (upd && !lf && sel_code == 3'h0 |=> $stable(o_micro_pc)
        && $stable(o_alternate_micro_pc) && $stable(o_next_address_latch)) else $error("wait changed a register");
    step_inc_a: assert property (upd && !lf && sel_code == 3'h1 |=> o_micro_pc == $past(o_micro_pc) + 14'h0001
        && o_next_address_latch == o_micro_pc) else $error("step did not add one");
    save_copy_a: assert property (upd && !lf && sel_code == 3'h2 |=> o_alternate_micro_pc == $past(o_micro_pc))
        else $error("save did not copy counter");
    skip_two_a: assert property (upd && !lf && sel_code == 3'h3 |=> o_micro_pc == $past(o_micro_pc) + 14'h0002)
        else $error("skip did not add two");
    out_of_line_once_once_a: assert property (upd && !lf && sel_code == 3'h4 |=> $stable(o_micro_pc)
        && o_next_address_latch == $past(o_alternate_micro_pc) + 14'h0001) else $error("execute-once wrong");
    call_swap_a: assert property (upd && !lf && sel_code == 3'h6 |=> o_alternate_micro_pc == $past(o_micro_pc)
        && o_micro_pc == $past(o_alternate_micro_pc) + 14'h0001) else $error("call wrong");
    jump_alt_a: assert property (upd && !lf && sel_code == 3'h5 |=> $stable(o_alternate_micro_pc)
        && o_micro_pc == $past(o_alternate_micro_pc) + 14'h0001 && o_next_address_latch == o_micro_pc)
        else $error("jump did not load alternate plus one");
    return_successor_two_a: assert property (upd && !lf && sel_code == 3'h7
        |=> o_micro_pc == $past(o_alternate_micro_pc) + 14'h0002) else $error("return did not add two");
    long_jump_a: assert property (upd && i_seq_mode_n && !i_force_long_form && i_microprogram_store[15:14] == 2'h1
        |=> o_next_address_latch == $past(word_addr) + 14'h0001) else $error("long jump target wrong");
    hold_freeze_a: assert property (i_phase1 && i_hold_sequencer && !i_clear |=> $stable(o_micro_pc)
        && $stable(o_next_address_latch)) else $error("hold did not freeze counter");
    long_ind_a: assert property (i_phase1 |=> o_long_form_instr == $past(lf))
        else $error("long-form indicator wrong");
    inhibit_val_a: assert property (i_phase1 |=> o_phase3_inhibit == $past(inh_want))
        else $error("phase 3 inhibit wrong");
    p3_gate_a: assert property (o_phase3_enable == (!o_phase3_inhibit && i_phase3))
        else $error("phase 3 enable not gated");
    clear_zero_a: assert property (i_clear |=> o_micro_pc == 14'h0000 && o_alternate_micro_pc == 14'h0000
        && o_next_address_latch == 14'h0000) else $error("clear left a register nonzero");
endmodule
bind mps_sequencer mps_sequencer_chk i_mps_sequencer_chk (.*);
`default_nettype wire

// *** testbench/mps_phase_model.sv ***
/* mps_phase_model: phase strobe source standing in for the nanomemory control side.
   assumes: one request per microinstruction from the bench, on the system clock. */
`timescale 1ns/1ns
`default_nettype none
module mps_phase_model (
    input  wire logic I_CLK_SYS, // system clock
    input  wire logic I_RST,     // synchronous reset
    input  wire logic i_req,     // start one microinstruction
    output var logic  o_phase1,  // phase 1 strobe
    output var logic  o_phase3   // phase 3 strobe
);
    // phase 1 one edge after a request, phase 3 on the next; strobes rest low between instructions
    always_ff @(posedge I_CLK_SYS) begin
        o_phase1 <= !I_RST && i_req;
        o_phase3 <= !I_RST && o_phase1;
    end
endmodule
`default_nettype wire

// *** testbench/mps_sequencer_tb.sv ***
/* mps_sequencer_tb: self-checking bench for the microprogram sequencer.
   assumes: mps_phase_model supplies the strobes; expectations kept in bench copies of the registers. */
`timescale 1ns/1ns
`default_nettype none
module mps_sequencer_tb;
    logic        I_CLK_SYS, I_RST, i_phase1, i_phase3, i_condition_result, i_phase3_conditional_bit, req;
    logic [2:0]  i_true_succ_code, i_false_succ_code, o_succ_code;
    logic [15:0] i_microprogram_store;
    logic        i_force_long_form, i_seq_mode_n, i_manual_step, i_clear, i_hold_sequencer;
    logic [13:0] o_micro_pc, o_alternate_micro_pc, o_next_address_latch, e_pc, e_alt, e_lat;
    logic        o_long_form_instr, o_phase3_inhibit, o_phase3_enable, o_load_alt_from_word;
    logic        o_load_shift_amount, o_load_constant, o_short_form;
    logic [7:0]  o_nano_address;
    int          fail_count, tests_run;
    logic [15:0] long_words [8] = '{16'h4ABC, 16'h8123, 16'h7FFF, 16'hC0FF, 16'hD0FF, 16'hE0FF, 16'hB555, 16'h0123};

    mps_sequencer i_mps_sequencer (.*);
    mps_phase_model i_mps_phase_model (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_req(req),
                                       .o_phase1(i_phase1), .o_phase3(i_phase3));

    initial begin
        I_CLK_SYS = 1'b0;
        forever #4 I_CLK_SYS = ~I_CLK_SYS;
    end

    // -----------------------------------------------------------------
    // compare, predict and run one microinstruction
    // -----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // m bits: 0 hold, 1 force long form, 2 sequential mode low, 3 manual step, 4 clear
    task automatic run(input logic c, input logic [2:0] t, input logic [2:0] f, input logic n6,
                       input logic [15:0] w, input logic [4:0] m);
        logic [2:0]  code;
        logic        lf, bc, inh;
        logic [13:0] nxt, n_pc, n_lat, n_alt;
        code  = c ? t : f;
        lf    = (w[15:12] != 4'hF) || (m[4:1] != 4'h0);
        bc    = !m[1] && !m[2] && (w[15] != w[14]);
        inh   = lf || (!c && n6);
        nxt   = (code[2] ? e_alt : e_pc) + ((code[1:0] == 2'h3) ? 14'h0002 : 14'h0001);
        if (lf) nxt = (bc ? w[13:0] : e_pc) + 14'h0001;
        n_pc  = (m[0] || (!lf && (code == 3'h0 || code == 3'h4))) ? e_pc : nxt;
        n_lat = (m[0] || (!lf && code == 3'h0)) ? e_lat : nxt;
        n_alt = ((!lf && code[1:0] == 2'h2) || (lf && bc && w[15])) ? e_pc : e_alt;
        e_pc  = m[4] ? 14'h0000 : n_pc;
        e_alt = m[4] ? 14'h0000 : n_alt;
        e_lat = m[4] ? 14'h0000 : n_lat;
        @(posedge I_CLK_SYS);
        i_condition_result       <= c;
        i_true_succ_code         <= t;
        i_false_succ_code        <= f;
        i_phase3_conditional_bit <= n6;
        i_microprogram_store     <= w;
        i_hold_sequencer         <= m[0];
        i_force_long_form        <= m[1];
        i_seq_mode_n             <= !m[2];
        i_manual_step            <= m[3];
        i_clear                  <= m[4];
        req                      <= 1'b1;
        @(posedge I_CLK_SYS);
        req <= 1'b0;
        // the phase 1 edge: registers load and phase 3 rises
        @(posedge I_CLK_SYS);
        #1;
        chk(o_micro_pc, e_pc, "counter");
        chk(o_next_address_latch, e_lat, "latch");
        chk(o_alternate_micro_pc, e_alt, "alternate");
        chk(o_succ_code, code, "successor");
        chk(o_long_form_instr, lf, "long form");
        chk(o_phase3_inhibit, inh, "inhibit");
        chk(o_phase3_enable, !inh, "phase 3 enable");
        chk(o_load_alt_from_word, w[15:14] == 2'h0, "alt load");
        chk(o_load_shift_amount, w[15:13] == 3'h6, "shift load");
        chk(o_load_constant, w[15:12] == 4'hC || w[15:12] == 4'hE, "constant load");
        chk(o_short_form, w[15:12] == 4'hF, "short form");
        chk(o_nano_address, w[7:0], "nano address");
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_long();
        foreach (long_words[i]) run(1'b1, 3'h7, 3'h0, 1'b0, long_words[i], 5'h00);
        run(1'b1, 3'h2, 3'h0, 1'b0, 16'hF011, 5'h00); // save copies the counter into the alternate
        $display("test long-form words done");
    endtask

    // every code from each group, the other group holding the inverse code
    task automatic t_short();
        for (int k = 0; k < 16; k++) begin
            run(k[3], k[3] ? k[2:0] : ~k[2:0], k[3] ? ~k[2:0] : k[2:0], 1'b1, {8'hF0, k[3:0], ~k[3:0]}, 5'h00);
        end
        $display("test successor codes done");
    endtask

    task automatic t_modes();
        run(1'b1, 3'h5, 3'h0, 1'b0, 16'h4321, 5'h02);
        run(1'b1, 3'h5, 3'h0, 1'b0, 16'h8321, 5'h04);
        run(1'b1, 3'h5, 3'h0, 1'b0, 16'hF321, 5'h08);
        run(1'b0, 3'h0, 3'h1, 1'b0, 16'hF321, 5'h00);
        $display("test long-form forcing done");
    endtask

    task automatic t_hold();
        run(1'b1, 3'h1, 3'h0, 1'b0, 16'hF000, 5'h01);
        run(1'b1, 3'h2, 3'h0, 1'b0, 16'hF000, 5'h01);
        run(1'b1, 3'h0, 3'h0, 1'b0, 16'h8155, 5'h01);
        run(1'b1, 3'h4, 3'h0, 1'b0, 16'hF000, 5'h00);
        $display("test hold done");
    endtask

    task automatic t_clear();
        run(1'b1, 3'h6, 3'h6, 1'b0, 16'hF000, 5'h10);
        run(1'b1, 3'h1, 3'h1, 1'b0, 16'hF000, 5'h00);
        $display("test clear done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // main sequence: reset, reset values, then the scenarios back to back
    initial begin
        {I_RST, i_seq_mode_n} = 2'h3;
        {i_condition_result, i_phase3_conditional_bit, req, i_force_long_form, i_manual_step} = 5'h00;
        {i_clear, i_hold_sequencer, i_true_succ_code, i_false_succ_code} = 8'h00;
        {i_microprogram_store, e_pc, e_alt, e_lat, fail_count, tests_run} = '0;
        repeat (3) @(posedge I_CLK_SYS);
        I_RST <= 1'b0;
        @(posedge I_CLK_SYS);
        #1;
        chk(o_micro_pc, 14'h0000, "reset counter");
        chk(o_succ_code, 3'h1, "reset successor");
        t_long();
        t_short();
        t_modes();
        t_hold();
        t_clear();
        test_done();
    end

    // watchdog: the scenarios need about 110 cycles
    initial begin
        repeat (4000) @(posedge I_CLK_SYS);
        fail_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done();
    end
endmodule
`default_nettype wire
